/* File: design/debug_scan_pkg.sv */
package debug_scan_pkg;

  // ****************************************************************
  // Chain geometry and selection codes
  // ****************************************************************
  localparam int         DATA_W       = 32;
  localparam int         CHAIN_LEN    = DATA_W + 1;
  localparam int         CNT_W        = 6;
  localparam logic [5:0] SHIFT_FULL   = 6'(CHAIN_LEN);
  localparam logic [3:0] CHAIN_DATA   = 4'h1;
  localparam logic [3:0] CHAIN_COPROC = 4'hf;
  // Extra run-test/idle clocks a coprocessor data word waits for
  localparam logic [1:0] CP_DATA_WAIT = 2'h1;

  // ****************************************************************
  // Debug status word layout
  // ****************************************************************
  localparam int STAT_W           = 5;
  localparam int STAT_ACK_BIT     = 0;
  localparam int STAT_MREQ_BIT    = 1;
  localparam int STAT_COMPACT_BIT = 4;

  // ****************************************************************
  // Program counter advance, in word addresses
  // ****************************************************************
  localparam int         PC_W          = 8;
  localparam logic [7:0] PC_ENTRY_BRK  = 8'h04;
  localparam logic [7:0] PC_ENTRY_REQ  = 8'h03;
  localparam logic [7:0] PC_STEP       = 8'h01;
  localparam logic [7:0] PC_SYS_ACCESS = 8'h03;

  typedef enum logic [1:0] {
    CAUSE_BREAKPOINT = 2'b00,
    CAUSE_WATCHPOINT = 2'b01,
    CAUSE_REQUEST    = 2'b10,
    CAUSE_WATCH_EXC  = 2'b11
  } entry_cause_type;

  typedef enum logic [2:0] {
    SYS_RUN    = 3'b000,
    SYS_DEBUG  = 3'b001,
    SYS_SYNC   = 3'b010,
    SYS_REQ    = 3'b011,
    SYS_ACCESS = 3'b100
  } sys_state_type;

  typedef struct packed {
    logic              brk;
    logic [DATA_W-1:0] data;
  } scan_word_type;

  typedef struct packed {
    logic              is_instr;
    logic [DATA_W-1:0] data;
  } coproc_word_type;

endpackage

/* File: design/debug_state_scan_execution.sv */
`timescale 1ns/1ps
`default_nettype none

module debug_state_scan_execution #(
  parameter int CHAIN_LEN = debug_scan_pkg::CHAIN_LEN
) (
  input  wire logic                            i_sys_clk,
  input  wire logic                            i_rst_n,
  input  wire logic                            i_tck,
  input  wire logic                            i_tap_capture_dr,
  input  wire logic                            i_tap_shift_dr,
  input  wire logic                            i_tap_update_dr,
  input  wire logic                            i_tap_run_idle,
  input  wire logic                            i_tdi,
  input  wire logic [3:0]                      i_chain_select,
  input  wire logic                            i_instr_intest,
  input  wire logic                            i_instr_bypass,
  input  wire logic                            i_instr_resume,
  input  wire logic [debug_scan_pkg::DATA_W-1:0] i_core_data,
  input  wire logic                            i_debug_entry,
  input  wire debug_scan_pkg::entry_cause_type i_entry_cause,
  input  wire logic                            i_compact_state,
  input  wire logic                            i_bus_grant,
  input  wire logic                            i_access_done,
  output logic                                 o_tdo,
  output logic                                 o_debug_clock,
  output debug_scan_pkg::scan_word_type        o_core_instr,
  output logic                                 o_cp_strobe,
  output debug_scan_pkg::coproc_word_type      o_cp_word,
  output logic                                 o_mem_req_n,
  output logic                                 o_debug_ack,
  output logic                                 o_in_debug,
  output logic                                 o_mode_unlock,
  output logic                                 o_fetch_resume,
  output logic [debug_scan_pkg::STAT_W-1:0]    o_debug_status,
  output logic [debug_scan_pkg::PC_W-1:0]      o_pc_advance
);

  if (CHAIN_LEN != debug_scan_pkg::DATA_W + 1) begin : g_len_check
    $error("CHAIN_LEN must be data width plus one");
  end

  function automatic logic full_update(input logic upd, input logic [3:0] sel,
                                       input logic [3:0] code, input logic [5:0] cnt_v);
    full_update = upd && (sel == code) && (cnt_v == debug_scan_pkg::SHIFT_FULL);
  endfunction

  // ****************************************************************
  // Test clock domain
  // ****************************************************************
  logic [CHAIN_LEN-1:0]                 sr;
  logic [CHAIN_LEN-1:0]                 next_sr;
  logic [debug_scan_pkg::CNT_W-1:0]     cnt;
  debug_scan_pkg::scan_word_type        held;
  debug_scan_pkg::coproc_word_type      cp_hold;
  logic                                 instr_loaded;
  logic                                 armed;
  logic                                 sys_pending;
  logic                                 busy;
  logic                                 return_flag;
  logic                                 run_idle_q;
  logic                                 rti_entry;
  logic                                 cp_ready;
  logic [1:0]                           cp_wait;
  logic [2:0]                           tck_tgl;
  logic                                 dbg_meta;
  logic                                 tck_in_debug;
  logic                                 done_meta;
  logic                                 done_sync;
  logic                                 done_prev;
  logic                                 done_edge;
  logic                                 done_tgl;
  logic                                 data_upd;
  logic                                 cp_upd;

  assign rti_entry = i_tap_run_idle && !run_idle_q;
  assign done_edge = done_sync ^ done_prev;
  assign data_upd  = full_update(i_tap_update_dr && i_instr_intest, i_chain_select,
                                 debug_scan_pkg::CHAIN_DATA, cnt);
  assign cp_upd    = full_update(i_tap_update_dr && tck_in_debug, i_chain_select,
                                 debug_scan_pkg::CHAIN_COPROC, cnt);

  always_comb begin
    next_sr = sr;
    if (i_tap_capture_dr) begin
      if (i_chain_select == debug_scan_pkg::CHAIN_DATA) begin
        next_sr = {return_flag, i_core_data};
      end else begin
        next_sr = '0;
      end
    end else if (i_tap_shift_dr) begin
      next_sr = {sr[CHAIN_LEN-2:0], i_tdi};
    end
  end

  always_ff @(posedge i_tck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sr    <= '0;
      o_tdo <= 1'b0;
      cnt   <= '0;
    end else begin
      sr    <= next_sr;
      o_tdo <= next_sr[CHAIN_LEN-1];
      if (i_tap_capture_dr) begin
        cnt <= '0;
      end else if (i_tap_shift_dr && !(&cnt)) begin
        cnt <= cnt + 6'h01;
      end
    end
  end

  // Crossings into the test clock domain
  always_ff @(posedge i_tck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dbg_meta     <= 1'b0;
      tck_in_debug <= 1'b0;
      done_meta    <= 1'b0;
      done_sync    <= 1'b0;
      done_prev    <= 1'b0;
      run_idle_q   <= 1'b0;
    end else begin
      dbg_meta     <= o_in_debug;
      tck_in_debug <= dbg_meta;
      done_meta    <= done_tgl;
      done_sync    <= done_meta;
      done_prev    <= done_sync;
      run_idle_q   <= i_tap_run_idle;
    end
  end

  // ****************************************************************
  // Instruction stepping and system-speed hand-off
  // ****************************************************************
  always_ff @(posedge i_tck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held          <= '0;
      instr_loaded  <= 1'b0;
      o_core_instr  <= '0;
      o_debug_clock <= 1'b0;
      armed         <= 1'b0;
      sys_pending   <= 1'b0;
      busy          <= 1'b0;
      tck_tgl       <= '0;
    end else begin
      o_debug_clock <= 1'b0;
      if (data_upd && tck_in_debug) begin
        held         <= sr;
        instr_loaded <= 1'b1;
      end else if (rti_entry && instr_loaded && i_instr_intest && tck_in_debug) begin
        o_debug_clock <= 1'b1;
        o_core_instr  <= held;
        instr_loaded  <= 1'b0;
        armed         <= held.brk;
        if (armed) begin
          sys_pending <= 1'b1;
        end else begin
          tck_tgl[0] <= ~tck_tgl[0];
        end
      end
      if (sys_pending && i_instr_bypass && !busy) begin
        tck_tgl[1]  <= ~tck_tgl[1];
        sys_pending <= 1'b0;
        busy        <= 1'b1;
      end else if (done_edge) begin
        busy <= 1'b0;
      end
      // Deferred to idle entry so several cores restart together
      if (rti_entry && i_instr_resume && tck_in_debug && !busy) begin
        tck_tgl[2]  <= ~tck_tgl[2];
        sys_pending <= 1'b0;
        armed       <= 1'b0;
      end
    end
  end

  // Reported once, on the next data chain capture
  always_ff @(posedge i_tck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      return_flag <= 1'b0;
    end else if (done_edge) begin
      return_flag <= 1'b1;
    end else if (i_tap_capture_dr && i_chain_select == debug_scan_pkg::CHAIN_DATA) begin
      return_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // Coprocessor chain
  // ****************************************************************
  always_ff @(posedge i_tck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cp_hold     <= '0;
      cp_ready    <= 1'b0;
      cp_wait     <= '0;
      o_cp_strobe <= 1'b0;
      o_cp_word   <= '0;
    end else begin
      o_cp_strobe <= 1'b0;
      if (cp_upd) begin
        cp_hold  <= sr;
        cp_ready <= 1'b1;
        cp_wait  <= sr[CHAIN_LEN-1] ? 2'h0 : debug_scan_pkg::CP_DATA_WAIT;
      end else if (cp_ready && i_tap_run_idle) begin
        if (cp_wait == 2'h0) begin
          o_cp_strobe <= 1'b1;
          o_cp_word   <= cp_hold;
          cp_ready    <= 1'b0;
        end else begin
          cp_wait <= cp_wait - 2'h1;
        end
      end
    end
  end

  // ****************************************************************
  // System clock domain
  // ****************************************************************
  debug_scan_pkg::sys_state_type state;
  logic [2:0]                    tgl_meta;
  logic [2:0]                    tgl_sync;
  logic [2:0]                    tgl_prev;
  logic [2:0]                    tgl_edge;
  logic                          compact_at_entry;
  logic                          entry;
  logic                          access_end;

  assign tgl_edge   = tgl_sync ^ tgl_prev;
  assign entry      = (state == debug_scan_pkg::SYS_RUN) && i_debug_entry;
  assign access_end = (state == debug_scan_pkg::SYS_ACCESS) && i_access_done;

  generate
    for (genvar g = 0; g < 3; g++) begin : g_tgl_sync
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          tgl_meta[g] <= 1'b0;
          tgl_sync[g] <= 1'b0;
          tgl_prev[g] <= 1'b0;
        end else begin
          tgl_meta[g] <= tck_tgl[g];
          tgl_sync[g] <= tgl_meta[g];
          tgl_prev[g] <= tgl_sync[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state            <= debug_scan_pkg::SYS_RUN;
      o_debug_ack      <= 1'b0;
      o_mem_req_n      <= 1'b1;
      o_in_debug       <= 1'b0;
      o_mode_unlock    <= 1'b0;
      o_fetch_resume   <= 1'b0;
      done_tgl         <= 1'b0;
      compact_at_entry <= 1'b0;
    end else begin
      o_fetch_resume <= 1'b0;
      case (state)
        debug_scan_pkg::SYS_RUN: begin
          if (i_debug_entry) begin
            state            <= debug_scan_pkg::SYS_DEBUG;
            o_debug_ack      <= 1'b1;
            o_in_debug       <= 1'b1;
            o_mode_unlock    <= 1'b1;
            compact_at_entry <= i_compact_state;
          end
        end
        debug_scan_pkg::SYS_DEBUG: begin
          if (tgl_edge[2]) begin
            state          <= debug_scan_pkg::SYS_RUN;
            o_debug_ack    <= 1'b0;
            o_in_debug     <= 1'b0;
            o_mode_unlock  <= 1'b0;
            o_fetch_resume <= 1'b1;
          end else if (tgl_edge[1]) begin
            state       <= debug_scan_pkg::SYS_SYNC;
            o_debug_ack <= 1'b0;
          end
        end
        debug_scan_pkg::SYS_SYNC: begin
          state       <= debug_scan_pkg::SYS_REQ;
          o_mem_req_n <= 1'b0;
        end
        debug_scan_pkg::SYS_REQ: begin
          // Stalls here for as long as the bus is withheld
          if (i_bus_grant) begin
            state <= debug_scan_pkg::SYS_ACCESS;
          end
        end
        debug_scan_pkg::SYS_ACCESS: begin
          if (i_access_done) begin
            state       <= debug_scan_pkg::SYS_DEBUG;
            o_mem_req_n <= 1'b1;
            o_debug_ack <= 1'b1;
            done_tgl    <= ~done_tgl;
          end
        end
        default: begin
          state <= debug_scan_pkg::SYS_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pc_advance <= '0;
    end else if (entry) begin
      if (i_entry_cause == debug_scan_pkg::CAUSE_REQUEST ||
          i_entry_cause == debug_scan_pkg::CAUSE_WATCH_EXC) begin
        o_pc_advance <= debug_scan_pkg::PC_ENTRY_REQ;
      end else begin
        o_pc_advance <= debug_scan_pkg::PC_ENTRY_BRK;
      end
    end else if (state != debug_scan_pkg::SYS_RUN) begin
      o_pc_advance <= o_pc_advance + (tgl_edge[0] ? debug_scan_pkg::PC_STEP : 8'h00)
                    + (access_end ? debug_scan_pkg::PC_SYS_ACCESS : 8'h00);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_debug_status <= 5'h02;
    end else begin
      o_debug_status <= '0;
      o_debug_status[debug_scan_pkg::STAT_ACK_BIT]     <= o_debug_ack;
      o_debug_status[debug_scan_pkg::STAT_MREQ_BIT]    <= o_mem_req_n;
      o_debug_status[debug_scan_pkg::STAT_COMPACT_BIT] <= compact_at_entry;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seq_cp_data;
    cp_upd && !sr[CHAIN_LEN-1];
  endsequence

  sequence seq_cp_instr;
    cp_upd && sr[CHAIN_LEN-1];
  endsequence

  chk_pc_entry_brk: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    entry && i_entry_cause == debug_scan_pkg::CAUSE_BREAKPOINT
    |=> o_pc_advance == debug_scan_pkg::PC_ENTRY_BRK)
    else $error("breakpoint entry pc advance wrong");
  chk_pc_entry_req: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    entry && i_entry_cause == debug_scan_pkg::CAUSE_REQUEST
    |=> o_pc_advance == debug_scan_pkg::PC_ENTRY_REQ)
    else $error("request entry pc advance wrong");
  chk_compact_status: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    entry |=> ##1 o_debug_status[debug_scan_pkg::STAT_COMPACT_BIT] == $past(i_compact_state, 2))
    else $error("compact state flag wrong");
  chk_req_after_sync: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    state == debug_scan_pkg::SYS_SYNC |=> !o_mem_req_n && !o_debug_ack)
    else $error("memory request not driven low");
  chk_stall_no_grant: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    state == debug_scan_pkg::SYS_REQ && !i_bus_grant
    |=> state == debug_scan_pkg::SYS_REQ && !o_mem_req_n)
    else $error("access left request without grant");
  chk_access_end: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    access_end |=> o_mem_req_n && o_debug_ack
    ##1 o_debug_status[debug_scan_pkg::STAT_ACK_BIT] && o_debug_status[debug_scan_pkg::STAT_MREQ_BIT])
    else $error("access completion not shown");
  chk_return_flag: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    return_flag && i_tap_capture_dr && i_chain_select == debug_scan_pkg::CHAIN_DATA
    |=> sr[CHAIN_LEN-1])
    else $error("return flag not captured");
  chk_step_full: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    $rose(instr_loaded) |-> $past(cnt) == debug_scan_pkg::SHIFT_FULL)
    else $error("instruction loaded without full shift");
  chk_resume_idle: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    $changed(tck_tgl[2]) |-> $past(i_tap_run_idle && !run_idle_q))
    else $error("resume outside idle entry");
  chk_cp_data_wait: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    seq_cp_data ##1 i_tap_run_idle |=> (!o_cp_strobe && i_tap_run_idle) |=> o_cp_strobe)
    else $error("coprocessor data extra clock wrong");
  chk_cp_instr: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    seq_cp_instr ##1 i_tap_run_idle |=> o_cp_strobe && o_cp_word.is_instr)
    else $error("coprocessor instruction not issued");

endmodule

`default_nettype wire

/* File: tb/debug_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Debug host on the test port
// ****************************************************************
module debug_host_model (
  output logic       o_tck,
  output logic       o_capture,
  output logic       o_shift,
  output logic       o_update,
  output logic       o_run_idle,
  output logic       o_tdi,
  output logic [3:0] o_chain,
  output logic [2:0] o_instr,
  input  wire logic  i_tdo
);
  initial begin
    {o_tck, o_capture, o_shift, o_update, o_run_idle, o_tdi} = 6'h00;
    o_chain = 4'h1;
    o_instr = 3'h4;
  end

  // Test clock stands still between host operations
  task automatic pulse(input int n);
    repeat (n) begin
      #13 o_tck = 1'b1;
      #40 o_tck = 1'b0;
      #27;
    end
  endtask

  task automatic select(input logic [3:0] chain, input logic [2:0] instr);
    o_chain = chain;
    o_instr = instr;
    pulse(1);
  endtask

  task automatic rti(input int n);
    o_run_idle = 1'b1;
    pulse(n);
    o_run_idle = 1'b0;
    pulse(2);
  endtask

  // Msb first, so the breakpoint bit leaves and enters first
  task automatic scan(input logic [32:0] word, input int shifts, input int idle,
                      output logic [32:0] got);
    got = 33'h0;
    o_capture = 1'b1;
    pulse(1);
    o_capture = 1'b0;
    o_shift = 1'b1;
    for (int i = 32; i > 32 - shifts; i--) begin
      got[i] = i_tdo;
      o_tdi = word[i];
      pulse(1);
    end
    o_shift = 1'b0;
    // Released line shows no stale bit
    o_tdi = ~o_tdi;
    o_update = 1'b1;
    pulse(1);
    o_update = 1'b0;
    rti(idle);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_debug_state_scan_execution.sv */
`timescale 1ns/1ps
`default_nettype none

module test_debug_state_scan_execution;
  typedef struct packed {
    debug_scan_pkg::entry_cause_type cause;
    logic                            compact;
    logic [7:0]                      pc;
  } row_type;

  // ****************************************************************
  // Entry cases beside the view they should give
  // ****************************************************************
  row_type rows [4] = '{'{debug_scan_pkg::CAUSE_BREAKPOINT, 1'b1, 8'h04},
                       '{debug_scan_pkg::CAUSE_WATCHPOINT, 1'b0, 8'h04},
                       '{debug_scan_pkg::CAUSE_REQUEST, 1'b1, 8'h03},
                       '{debug_scan_pkg::CAUSE_WATCH_EXC, 1'b0, 8'h03}};
  logic                            i_sys_clk, i_rst_n, tck, cap, sh, upd, idle, tdi, tdo;
  logic                            entry, compact, grant, done;
  logic                            debug_clock, cp_strobe, mreq_n, ack, in_dbg, unlock, fetch;
  logic [3:0]                      chain;
  logic [2:0]                      instr;
  logic [31:0]                     core_data;
  logic [32:0]                     got;
  logic [7:0]                      pc;
  logic [4:0]                      status;
  debug_scan_pkg::entry_cause_type cause;
  debug_scan_pkg::scan_word_type   core_instr;
  debug_scan_pkg::coproc_word_type cp_word;
  int                              miscompares = 0, compares = 0, k;
  int                              n_debug_clock = 0, n_cp = 0, n_fetch = 0;

  debug_host_model debug_host_model_i (.o_tck(tck), .o_capture(cap), .o_shift(sh),
    .o_update(upd), .o_run_idle(idle), .o_tdi(tdi), .o_chain(chain), .o_instr(instr),
    .i_tdo(tdo));

  debug_state_scan_execution #(.CHAIN_LEN(33)) debug_state_scan_execution_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_tck(tck), .i_tap_capture_dr(cap),
    .i_tap_shift_dr(sh), .i_tap_update_dr(upd), .i_tap_run_idle(idle), .i_tdi(tdi),
    .i_chain_select(chain), .i_instr_intest(instr[2]), .i_instr_bypass(instr[1]),
    .i_instr_resume(instr[0]), .i_core_data(core_data), .i_debug_entry(entry),
    .i_entry_cause(cause), .i_compact_state(compact), .i_bus_grant(grant),
    .i_access_done(done), .o_tdo(tdo), .o_debug_clock(debug_clock), .o_core_instr(core_instr),
    .o_cp_strobe(cp_strobe), .o_cp_word(cp_word), .o_mem_req_n(mreq_n),
    .o_debug_ack(ack), .o_in_debug(in_dbg), .o_mode_unlock(unlock),
    .o_fetch_resume(fetch), .o_debug_status(status), .o_pc_advance(pc));

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // Counted mid-cycle, where the one-cycle pulses have settled
  always @(negedge tck) begin
    n_debug_clock <= n_debug_clock + int'(debug_clock);
    n_cp   <= n_cp + int'(cp_strobe);
  end
  always @(negedge i_sys_clk) n_fetch <= n_fetch + int'(fetch);

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic sys_wait(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic enter(input debug_scan_pkg::entry_cause_type c, input logic th);
    @(negedge i_sys_clk);
    entry = 1'b1;
    cause = c;
    compact = th;
    sys_wait(1);
    entry = 1'b0;
    sys_wait(2);
  endtask

  // A hang counts against the run
  initial begin
    #300us;
    miscompares++;
    give_verdict();
  end

  initial begin
    {i_rst_n, entry, compact, grant, done} = 5'h00;
    cause = debug_scan_pkg::CAUSE_BREAKPOINT;
    core_data = 32'ha5c3_0f96;
    fork
      debug_host_model_i.pulse(3);
      sys_wait(20);
    join
    check("reset", {mreq_n, status, pc, ack, in_dbg, unlock, fetch, debug_clock, cp_strobe, tdo},
          {1'b1, 5'h02, 15'h0000});
    i_rst_n = 1'b1;
    sys_wait(2);
    foreach (rows[r]) begin
      enter(rows[r].cause, rows[r].compact);
      check("entry", {ack, in_dbg, unlock, pc}, {3'b111, rows[r].pc});
      check("status", status, {rows[r].compact, 4'h3});
      debug_host_model_i.select(4'h1, 3'h1);
      debug_host_model_i.pulse(3);
      check("held", in_dbg, 1'b1);
      debug_host_model_i.rti(1);
      check("resume", {n_fetch[3:0], ack, in_dbg, unlock}, {4'(r + 1), 3'b000});
      debug_host_model_i.select(4'h1, 3'h4);
    end
    // ****************************************************************
    // Short frame refused, then a full one
    // ****************************************************************
    enter(debug_scan_pkg::CAUSE_BREAKPOINT, 1'b0);
    debug_host_model_i.pulse(2);
    debug_host_model_i.scan({1'b0, 32'h4700_4700}, 32, 1, got);
    check("short", {n_debug_clock[3:0], pc}, {4'h0, 8'h04});
    debug_host_model_i.scan({1'b0, 32'h4700_4700}, 33, 1, got);
    check("capture", got, {1'b0, core_data});
    check("core word", core_instr, {1'b0, 32'h4700_4700});
    sys_wait(4);
    check("step", {n_debug_clock[3:0], pc}, {4'h1, 8'h05});
    // ****************************************************************
    // System-speed access with the bus withheld
    // ****************************************************************
    debug_host_model_i.scan({1'b1, 32'he1a0_0000}, 33, 1, got);
    debug_host_model_i.scan({1'b0, 32'he891_00ff}, 33, 1, got);
    debug_host_model_i.select(4'h1, 3'h2);
    for (k = 0; k < 40 && mreq_n !== 1'b0; k++) sys_wait(1);
    sys_wait(20);
    check("stall", {mreq_n, ack}, 2'b00);
    grant = 1'b1;
    sys_wait(2);
    done = 1'b1;
    sys_wait(1);
    {grant, done} = 2'b00;
    for (k = 0; k < 20 && status[1:0] !== 2'b11; k++) sys_wait(1);
    check("done", {status[1:0], mreq_n, ack, pc}, {4'hf, 8'h09});
    debug_host_model_i.select(4'h1, 3'h4);
    debug_host_model_i.pulse(4);
    core_data = ~core_data;
    debug_host_model_i.scan({1'b0, 32'he1a0_0000}, 33, 1, got);
    check("flag set", got, {1'b1, 32'h5a3c_f069});
    debug_host_model_i.scan({1'b0, 32'he1a0_0000}, 33, 1, got);
    check("flag clear", got[32], 1'b0);
    // ****************************************************************
    // Coprocessor chain: data needs a second idle clock
    // ****************************************************************
    debug_host_model_i.select(4'hf, 3'h4);
    debug_host_model_i.scan({1'b1, 32'hee01_0f10}, 33, 1, got);
    check("cp instr", {n_cp[3:0], cp_word}, {4'h1, 33'h1_ee01_0f10});
    debug_host_model_i.scan({1'b0, 32'h0000_0079}, 33, 1, got);
    check("cp early", n_cp[3:0], 4'h1);
    debug_host_model_i.scan({1'b0, 32'h0000_0079}, 33, 2, got);
    check("cp data", {n_cp[3:0], cp_word}, {4'h2, 33'h0_0000_0079});
    // ****************************************************************
    // Exit: armed word, branch, resume
    // ****************************************************************
    debug_host_model_i.select(4'h1, 3'h4);
    debug_host_model_i.scan({1'b1, 32'he1a0_0000}, 33, 1, got);
    sys_wait(2);
    check("exit pc", pc, 8'h0c);
    debug_host_model_i.scan({1'b0, 32'heaff_fff0}, 33, 1, got);
    debug_host_model_i.select(4'h1, 3'h1);
    debug_host_model_i.rti(1);
    check("exit", {n_fetch[3:0], in_dbg, ack}, {4'h5, 2'b00});
    // ****************************************************************
    // Reset in mid-run, inside debug state
    // ****************************************************************
    enter(debug_scan_pkg::CAUSE_REQUEST, 1'b1);
    i_rst_n = 1'b0;
    sys_wait(2);
    check("mid reset", {mreq_n, status, pc, ack, in_dbg, unlock},
          {1'b1, 5'h02, 11'h000});
    i_rst_n = 1'b1;
    sys_wait(2);
    enter(debug_scan_pkg::CAUSE_WATCHPOINT, 1'b0);
    check("after reset", {ack, status, pc}, {1'b1, 5'h03, 8'h04});
    give_verdict();
  end
endmodule
`default_nettype wire
